//--- rscomb_src_model.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////
// Reset detectors and CPU event sources
module rscomb_src_model
(
   input wire logic aclk, // System clock
   input wire logic [3:0] kind, // Source to fire
   input wire logic fire, // Start one event
   output logic external_clear_pin_n, // Pin, active low
   output logic brownout_detect, // Level
   output logic watchdog_timeout, // Level
   output logic config_mismatch, // Level
   output logic software_reset_instr, // Pulse
   output logic trap_conflict, // Pulse
   output logic illegal_opcode, // Pulse
   output logic uninitialized_pointer_reset, // Pulse
   output logic clear_watchdog_instr, // Pulse
   output logic power_save_sleep, // Pulse
   output logic power_save_idle // Pulse
);
   logic [3:0] cur_reg = 4'hf; // Last fired source
   logic [2:0] hold_reg = 3'h0; // Cycles left
   logic [10:0] hit; // Active source, one-hot
   logic [10:0] pulse; // First cycle only
   // Levels last four cycles so they outlive the synchroniser
   always_ff @(posedge aclk)
   begin
      if (fire)
      begin
         cur_reg <= kind;
         hold_reg <= 3'h4;
      end
      else if (hold_reg != 3'h0)
         hold_reg <= hold_reg - 3'h1;
   end
   assign hit = (hold_reg != 3'h0) ? (11'h1 << cur_reg) : 11'h0;
   assign pulse = (hold_reg == 3'h4) ? hit : 11'h0;
   // CPU events are single-cycle
   assign trap_conflict = pulse[0];
   assign illegal_opcode = pulse[1];
   assign uninitialized_pointer_reset = pulse[2];
   assign software_reset_instr = pulse[3];
   assign external_clear_pin_n = ~hit[4];
   assign config_mismatch = hit[5];
   assign watchdog_timeout = hit[6];
   assign brownout_detect = hit[7];
   assign power_save_sleep = pulse[8];
   assign power_save_idle = pulse[9];
   assign clear_watchdog_instr = pulse[10];
endmodule : rscomb_src_model
`default_nettype wire

//--- rscomb_sync.sv
////////////////////////////////////////////////////////////////////////////////
// Shared constants of the reset source combiner
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`default_nettype none
package rscomb_pkg;
   // Register bus geometry
   localparam int RSCOMB_ADDR_W = 8;
   localparam logic [7:0] RSCOMB_RCC_OFFSET = 8'h00; // Reset cause and control word
   // Field positions inside the reset cause and control word
   localparam int RCC_TRAP_BIT = 15;
   localparam int RCC_ILLOP_BIT = 14;
   localparam int RCC_SBOR_BIT = 13;
   localparam int RCC_RETAIN_BIT = 12;
   localparam int RCC_MISMATCH_BIT = 9;
   localparam int RCC_FASTWK_BIT = 8;
   localparam int RCC_EXT_BIT = 7;
   localparam int RCC_SWRESET_BIT = 6;
   localparam int RCC_SWDT_BIT = 5;
   localparam int RCC_WDOG_BIT = 4;
   localparam int RCC_SLEEP_BIT = 3;
   localparam int RCC_IDLE_BIT = 2;
   localparam int RCC_BROWNOUT_BIT = 1;
   localparam int RCC_POR_BIT = 0;
   // Power-on value and writable bits
   localparam logic [15:0] RCC_POR_VALUE = 16'h2003;
   localparam logic [15:0] RCC_WRITE_MASK = 16'hf3ff;
   // Configuration field encodings
   localparam logic [1:0] BROWNOUT_CFG_SOFT = 2'b01;
   localparam logic [1:0] BROWNOUT_CFG_OFF = 2'b00;
   localparam logic [1:0] WDT_CFG_FORCED = 2'b11;
   // Reset stretch length in system clocks
   localparam int RSCOMB_HOLD_CYCLES = 16;
   // Bus response codes
   localparam logic [1:0] AXI_RESP_OKAY = 2'b00;
   localparam logic [1:0] AXI_RESP_DECERR = 2'b11;
   // Number of reset sources that come from outside the clock domain
   localparam int RSCOMB_ASYNC_SRC = 4;
endpackage : rscomb_pkg

////////////////////////////////////////////////////////////////////////////////
// Two-stage synchroniser for levels from outside the clock domain
////////////////////////////////////////////////////////////////////////////////
module rscomb_sync
#(
   parameter int WIDTH = 4 // Number of levels
)
(
   input wire logic aclk, // System clock
   input wire logic aresetn, // Root reset, active low
   input wire logic [WIDTH-1:0] async_in, // Raw levels
   output logic [WIDTH-1:0] sync_out // Levels safe to read
);
   logic [WIDTH-1:0] meta_reg; // First stage, read only by the second

   // Both stages; reset to inactive so no phantom reset follows power-on
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_reg <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : rscomb_sync

`default_nettype wire

//--- rscomb_top.sv
// How it works
// - Any active reset source asserts master reset
// - Each reset kind sets a flag; illegal opcode and pointer share one
// - Power-on clears flags, sets brown-out and power-on
// - Software may write flags; writes never reset
// - Flags survive every reset except power-on
// - Bit 15 records trap conflict resets
// - Bit 14 records illegal opcode or pointer
// - Bit 13 enables brown-out only if field 01
// - Bit 12 selects retention regulator, unless config set
// - Bits 11 and 10 always read zero
// - Bit 9 records configuration mismatch resets
// - Bit 8 chooses slow or fast wake-up
// - Bit 7 records external clear pin resets
// - Bit 6 records reset instruction execution
// - Watchdog field 11 forces watchdog enabled
// - Bit 4 set by timeout, cleared by instructions
// - Bit 3 records Sleep entry
// - Bit 2 records Idle entry
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none

module rscomb_top
   import rscomb_pkg::*;
#(
   parameter int HOLD_CYCLES = RSCOMB_HOLD_CYCLES // Reset stretch after last source
)
(
   input wire logic aclk, // System clock, 100 MHz
   input wire logic aresetn, // Power-on root reset, active low, synchronous
   // Reset sources from detectors outside the clock domain
   input wire logic external_clear_pin_n, // Master clear pin, active low
   input wire logic brownout_detect, // Supply below threshold
   input wire logic watchdog_timeout, // Watchdog expiry level
   input wire logic config_mismatch, // Configuration word mismatch
   // Events from the CPU core, same clock, one-cycle pulses
   input wire logic software_reset_instr, // Reset instruction executed
   input wire logic trap_conflict, // Trap conflict
   input wire logic illegal_opcode, // Illegal opcode or addressing mode
   input wire logic uninitialized_pointer_reset, // Uninitialised pointer used
   input wire logic clear_watchdog_instr, // Watchdog-clear instruction
   input wire logic power_save_sleep, // Power-save instruction, argument 0
   input wire logic power_save_idle, // Power-save instruction, argument 1
   // Configuration word fields, static after load
   input wire logic [1:0] brownout_config_field, // Brown-out mode
   input wire logic [1:0] watchdog_config_field, // Watchdog mode
   input wire logic low_power_regulator_config, // 1 disables retention regulator
   // Outputs to the rest of the chip
   output logic master_system_reset, // Combined reset, active high
   output logic brownout_detect_enable, // Brown-out detector on
   output logic retention_regulator_select, // Use retention regulator in Sleep
   output logic regulator_standby_in_sleep, // Slow wake, lower power
   output logic watchdog_enable, // Watchdog running
   // AXI4-Lite slave
   input wire logic [RSCOMB_ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [RSCOMB_ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready // Read data ready
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   ////////////////////////////////////////////////////////////////////////////

   // Word address decode, byte offset ignored within the word
   function automatic logic rcc_hit(input logic [RSCOMB_ADDR_W-1:0] addr);
      rcc_hit = (addr[RSCOMB_ADDR_W-1:2] == RSCOMB_RCC_OFFSET[RSCOMB_ADDR_W-1:2]);
   endfunction : rcc_hit

   ////////////////////////////////////////////////////////////////////////////
   // Synchronised outside sources
   ////////////////////////////////////////////////////////////////////////////
   logic [RSCOMB_ASYNC_SRC-1:0] src_sync; // Synchronised levels
   logic ext_active; // Clear pin held low
   logic brownout_active; // Brown-out level
   logic wdt_active; // Watchdog timeout level
   logic mismatch_active; // Mismatch level

   rscomb_sync #(.WIDTH(RSCOMB_ASYNC_SRC)) u_sync
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({config_mismatch, watchdog_timeout, brownout_detect, ~external_clear_pin_n}),
      .sync_out(src_sync)
   );

   assign ext_active = src_sync[0];
   assign brownout_active = src_sync[1] & brownout_detect_enable; // Detector gated by enable
   assign wdt_active = src_sync[2];
   assign mismatch_active = src_sync[3];

   ////////////////////////////////////////////////////////////////////////////
   // Reset combining and stretching
   ////////////////////////////////////////////////////////////////////////////
   logic illop_any; // Illegal opcode or pointer
   logic src_any; // Any reset source active
   logic [15:0] hold_cnt_reg; // Cycles of stretch left

   assign illop_any = illegal_opcode | uninitialized_pointer_reset;
   assign src_any = ext_active | brownout_active | wdt_active | mismatch_active
                  | software_reset_instr | trap_conflict | illop_any;

   // Stretch counter; a one-cycle pulse still gives a full-length reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         hold_cnt_reg <= 16'(HOLD_CYCLES);
      else if (src_any)
         hold_cnt_reg <= 16'(HOLD_CYCLES);
      else if (hold_cnt_reg != 16'h0000)
         hold_cnt_reg <= hold_cnt_reg - 16'h0001;
   end

   // Master reset: any source, or the stretch after power-on or a source
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         master_system_reset <= 1'b1;
      else
         master_system_reset <= src_any | (hold_cnt_reg != 16'h0000);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write channel of the bus slave
   ////////////////////////////////////////////////////////////////////////////
   logic aw_got_reg; // Address held
   logic w_got_reg; // Data held
   logic [RSCOMB_ADDR_W-1:0] awaddr_reg; // Held address
   logic [15:0] wdata_reg; // Held low half of data
   logic [1:0] wstrb_reg; // Held low strobes
   logic wr_fire; // Write performed this cycle
   logic wr_hit; // Write hits the register

   assign wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
   assign wr_hit = rcc_hit(awaddr_reg);

   // Address capture; ready stays low until the response is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_reg <= 1'b0;
         awaddr_reg <= '0;
         s_axi_awready <= 1'b1;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_got_reg <= 1'b1;
         awaddr_reg <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end
      else if (wr_fire)
         aw_got_reg <= 1'b0;
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_awready <= 1'b1;
   end

   // Data capture; upper half of the word has no storage
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_got_reg <= 1'b0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
         s_axi_wready <= 1'b1;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_got_reg <= 1'b1;
         wdata_reg <= s_axi_wdata[15:0];
         wstrb_reg <= s_axi_wstrb[1:0];
         s_axi_wready <= 1'b0;
      end
      else if (wr_fire)
         w_got_reg <= 1'b0;
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_wready <= 1'b1;
   end

   // Response follows both halves; unmapped words answer decode error
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? AXI_RESP_OKAY : AXI_RESP_DECERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset cause and control register
   ////////////////////////////////////////////////////////////////////////////
   logic [15:0] rcc_reg; // Reset cause and control word
   logic [15:0] rcc_next; // Its next value
   logic [15:0] sw_mask; // Bits software writes this cycle
   logic [15:0] hw_set; // Bits hardware sets this cycle

   // Hardware flag sets, one per flag; illegal opcode and pointer share bit 14
   always_comb
   begin
      hw_set = 16'h0000;
      hw_set[RCC_TRAP_BIT] = trap_conflict;
      hw_set[RCC_ILLOP_BIT] = illop_any;
      hw_set[RCC_MISMATCH_BIT] = mismatch_active;
      hw_set[RCC_EXT_BIT] = ext_active;
      hw_set[RCC_SWRESET_BIT] = software_reset_instr;
      hw_set[RCC_WDOG_BIT] = wdt_active;
      hw_set[RCC_SLEEP_BIT] = power_save_sleep;
      hw_set[RCC_IDLE_BIT] = power_save_idle;
      hw_set[RCC_BROWNOUT_BIT] = brownout_active;
   end

   // Write, then instruction clears, then hardware sets on top
   always_comb
   begin
      sw_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}} & RCC_WRITE_MASK;
      rcc_next = rcc_reg;
      if (wr_fire && wr_hit)
         rcc_next = (rcc_reg & ~sw_mask) | (wdata_reg & sw_mask);
      if (clear_watchdog_instr || power_save_sleep || power_save_idle)
         rcc_next[RCC_WDOG_BIT] = 1'b0;
      rcc_next = rcc_next | hw_set;
   end

   // Only the power-on root reset touches it; master reset does not
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rcc_reg <= RCC_POR_VALUE;
      else
         rcc_reg <= rcc_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Controls driven from the register
   ////////////////////////////////////////////////////////////////////////////

   // Effective enables; other brown-out modes ignore the soft bit
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         brownout_detect_enable <= 1'b0;
         retention_regulator_select <= 1'b0;
         regulator_standby_in_sleep <= 1'b0;
         watchdog_enable <= 1'b0;
      end
      else
      begin
         if (brownout_config_field == BROWNOUT_CFG_SOFT)
            brownout_detect_enable <= rcc_reg[RCC_SBOR_BIT];
         else
            brownout_detect_enable <= (brownout_config_field != BROWNOUT_CFG_OFF);
         retention_regulator_select <= rcc_reg[RCC_RETAIN_BIT]
                                     & ~low_power_regulator_config;
         regulator_standby_in_sleep <= rcc_reg[RCC_FASTWK_BIT];
         watchdog_enable <= (watchdog_config_field == WDT_CFG_FORCED)
                          | rcc_reg[RCC_SWDT_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel of the bus slave
   ////////////////////////////////////////////////////////////////////////////

   // One read in flight; data latched at the address handshake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= AXI_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         if (rcc_hit(s_axi_araddr))
         begin
            s_axi_rdata <= {16'h0000, rcc_reg & RCC_WRITE_MASK};
            s_axi_rresp <= AXI_RESP_OKAY;
         end
         else
         begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= AXI_RESP_DECERR;
         end
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   ////////////////////////////////////////////////////////////////////////////

   // Pin held low long enough to cross both stages and set the flag
   sequence s_pin_held;
      (!external_clear_pin_n) [*3];
   endsequence

   // Mismatch level held across the synchroniser
   sequence s_mismatch_held;
      config_mismatch [*3];
   endsequence

   a_master_any_src: assert property (@(posedge aclk) disable iff (!aresetn)
      src_any |=> master_system_reset [*2])
      else $error("Master reset not asserted for an active source");

   a_por_value: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> (rcc_reg == RCC_POR_VALUE) && master_system_reset)
      else $error("Power-on value wrong");

   a_trap_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      trap_conflict |=> rcc_reg[RCC_TRAP_BIT] && master_system_reset)
      else $error("Trap conflict flag not set");

   a_illop_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      (illegal_opcode || uninitialized_pointer_reset) |=> rcc_reg[RCC_ILLOP_BIT])
      else $error("Illegal opcode flag not set");

   a_ext_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      s_pin_held |=> rcc_reg[RCC_EXT_BIT] && master_system_reset)
      else $error("External pin flag not set");

   a_mismatch_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      s_mismatch_held |=> rcc_reg[RCC_MISMATCH_BIT])
      else $error("Mismatch flag not set");

   a_swreset_beats_write: assert property (@(posedge aclk) disable iff (!aresetn)
      software_reset_instr && wr_fire |=> rcc_reg[RCC_SWRESET_BIT])
      else $error("Write overrode reset instruction flag");

   a_write_no_reset: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && !src_any && !master_system_reset && hold_cnt_reg == 16'h0000
      |=> !master_system_reset)
      else $error("Software write caused a reset");

   a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> s_axi_rdata[11:10] == 2'b00 && rcc_reg[11:10] == 2'b00)
      else $error("Unimplemented bits not zero");

   // Enable is registered, so it shows the soft bit one cycle later
   a_brownout_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      brownout_config_field == BROWNOUT_CFG_SOFT && $stable(brownout_config_field)
      |=> brownout_detect_enable == $past(rcc_reg[RCC_SBOR_BIT]))
      else $error("Brown-out enable ignores soft bit");

   a_retain_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(low_power_regulator_config) |-> !retention_regulator_select)
      else $error("Retention selected while config forbids it");

   a_fast_wake: assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |=> regulator_standby_in_sleep == $past(rcc_reg[RCC_FASTWK_BIT]))
      else $error("Wake-up speed output does not follow bit 8");

   a_wdt_forced: assert property (@(posedge aclk) disable iff (!aresetn)
      watchdog_config_field == WDT_CFG_FORCED |=> watchdog_enable)
      else $error("Watchdog not forced on");

   a_wdog_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      clear_watchdog_instr && !wdt_active |=> !rcc_reg[RCC_WDOG_BIT])
      else $error("Watchdog flag not cleared");

   a_sleep_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      power_save_sleep |=> rcc_reg[RCC_SLEEP_BIT])
      else $error("Sleep flag not set");

   a_idle_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      power_save_idle |=> rcc_reg[RCC_IDLE_BIT])
      else $error("Idle flag not set");

   a_flags_keep: assert property (@(posedge aclk) disable iff (!aresetn)
      master_system_reset && !wr_fire && hw_set == 16'h0000 && !clear_watchdog_instr
      && !power_save_sleep && !power_save_idle |=> $stable(rcc_reg))
      else $error("Register changed by a non-power-on reset");

endmodule : rscomb_top

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import rscomb_pkg::*;
   logic aclk = 1'h0, aresetn = 1'h0, fire = 1'h0, low_power_regulator_config = 1'h0;
   logic [3:0] kind = 4'h0, s_axi_wstrb = 4'hf;
   logic [1:0] brownout_config_field = 2'h1, watchdog_config_field = 2'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic external_clear_pin_n, brownout_detect, watchdog_timeout, config_mismatch;
   logic software_reset_instr, trap_conflict, illegal_opcode, uninitialized_pointer_reset;
   logic clear_watchdog_instr, power_save_sleep, power_save_idle, master_system_reset;
   logic brownout_detect_enable, retention_regulator_select, regulator_standby_in_sleep;
   logic watchdog_enable, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   int fails = 0, samples_checked = 0, cycles = 0, k, n;
   // Flag expected per source kind, in model order
   logic [15:0] masks [11] = '{16'h8000, 16'h4000, 16'h4000, 16'h0040, 16'h0080,
      16'h0200, 16'h0010, 16'h0002, 16'h0008, 16'h0004, 16'h0000};
   ////////////////////////////////////////
   always #5 aclk = ~aclk;
   // Short stretch keeps each source test brief
   rscomb_top #(.HOLD_CYCLES(2)) i_rscomb_top (.*);
   rscomb_src_model i_rscomb_src_model (.*);
   ////////////////////////////////////////
   task complete_run;
      if (fails == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : complete_run
   // Cut a hang short
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         complete_run();
      end
   end
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Address and data offered together, each dropped when taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'h0;
      end
      while (s_axi_bvalid !== 1'h1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask : wr
   task rd_t(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'h0;
      end
      while (s_axi_rvalid !== 1'h1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : rd_t
   task wait_rst(input logic v);
      for (n = 0; n < 40 && master_system_reset !== v; n++)
         @(posedge aclk);
      chk("master reset", {31'h0, v}, {31'h0, master_system_reset});
   endtask : wait_rst
   task por;
      aresetn <= 1'h0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      wait_rst(1'h0);
      rd_t(8'h0);
      chk("rcc after power-on", 32'h2003, rd);
   endtask : por
   task fire_src(input logic [3:0] s);
      @(posedge aclk);
      kind <= s;
      fire <= 1'h1;
      @(posedge aclk);
      fire <= 1'h0;
   endtask : fire_src
   task outs(input logic [3:0] e);
      repeat (2) @(posedge aclk);
      chk("retention", {31'h0, e[3]}, {31'h0, retention_regulator_select});
      chk("standby", {31'h0, e[2]}, {31'h0, regulator_standby_in_sleep});
      chk("brownout on", {31'h0, e[1]}, {31'h0, brownout_detect_enable});
      chk("watchdog on", {31'h0, e[0]}, {31'h0, watchdog_enable});
   endtask : outs
   ////////////////////////////////////////
   initial
   begin
      por();
      // Writing every flag must not reset the device
      wr(8'h0, 32'hffff_ffff);
      chk("master reset", 32'h0, {31'h0, master_system_reset});
      rd_t(8'h0);
      chk("rcc all ones", 32'hf3ff, rd);
      outs(4'hf);
      // Brown-out field 00 forces off and 10 forces on, whatever bit 13 holds
      brownout_config_field <= 2'h0;
      outs(4'hd);
      brownout_config_field <= 2'h2;
      low_power_regulator_config <= 1'h1;
      wr(8'h0, 32'h1000);
      outs(4'h2);
      brownout_config_field <= 2'h1;
      watchdog_config_field <= 2'h3;
      outs(4'h1);
      // Disabled detector: no reset and no flag
      fire_src(4'h7);
      repeat (6) @(posedge aclk);
      chk("no brown-out reset", 32'h0, {31'h0, master_system_reset});
      // Unmapped word is refused and has no effect
      wr(8'h04, 32'hffff);
      chk("bresp", 32'h3, {30'h0, resp});
      rd_t(8'h04);
      chk("rresp", 32'h3, {30'h0, resp});
      chk("rdata", 32'h0, rd);
      rd_t(8'h0);
      chk("rcc kept", 32'h1000, rd);
      // Each source from a known start; flags cleared first, except the watchdog flag ahead of its clear instruction
      for (k = 0; k < 11; k++)
      begin
         wr(8'h0, (k == 10) ? 32'h2010 : 32'h2000);
         fire_src(k[3:0]);
         if (k < 8)
         begin
            wait_rst(1'h1);
            wait_rst(1'h0);
         end
         else
         begin
            repeat (6) @(posedge aclk);
            chk("no reset", 32'h0, {31'h0, master_system_reset});
         end
         rd_t(8'h0);
         chk("rcc source", {16'h0, 16'h2000 | masks[k]}, rd);
         // Also the other flags
      end
      // Reset instruction in the very cycle of a write that clears its flag
      fork
         wr(8'h0, 32'h0);
         fire_src(4'h3);
      join
      wait_rst(1'h1);
      wait_rst(1'h0);
      rd_t(8'h0);
      chk("set beats write", 32'h0040, rd);
      // Second power-on in mid-run clears recorded flags
      wr(8'h0, 32'hc2c4);
      por();
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
